// ### shared/pmx_pkg.sv
// constants for the port a/b alternate function mux
//
// Overview of operation
// - pa7..pa4 carry front plane lines 3..0 when display owns them.
// - pa3..pa0 carry back plane lines 3..0 when display owns them.
// - display on forces pa7..pa4 pull-up, driver, input off; pad to analog line.
// - pa3..pa1 override gated by display on and mux select; pa0 by display alone.
// - pb7..pb4 carry timer compare outputs, only with direction bit set.
// - the same pins carry timer pwm waveforms in pwm modes.
// - pb7..pb0 feed pin change sources 15..8.
// - spi master forces pb3 to input, feeding master receive.
// - spi slave leaves pb3 direction to its direction bit.
// - spi slave forces pb2 to input, feeding slave receive.
// - spi master leaves pb2 direction to its direction bit.
// - spi slave forces pb1 to input as incoming serial clock.
// - spi master leaves pb1 direction to its direction bit.
// - forced spi inputs keep pull-up under port output bit control.
// - pb0 is slave select input or pin change source 8.
// - pull-up follows override value, else on when dir,port,disable is 0,1,0.
// - driver follows override value when enabled, else direction bit.
// - input enable follows override value when enabled, else inverse of sleep state.
package pmx_pkg;
  localparam int          PORT_W        = 8;
  localparam int          FRONT_LO      = 4;
  localparam int          NLINES        = 4;
  localparam logic [2:0]  PU_NORMAL     = 3'h2;
  localparam logic [7:0]  PB_SPI_MASK   = 8'h0E;
  localparam logic [7:0]  PB_TIMER_MASK = 8'hF0;
  localparam logic [7:0]  PB_RESET      = 8'h00;
  localparam int          BIT_SS        = 0;
  localparam int          BIT_SCK       = 1;
  localparam int          BIT_MOSI      = 2;
  localparam int          BIT_MISO      = 3;
endpackage

// ### src/pmx_port_ab_mux.sv
// pad override mux for ports a and b
`timescale 1ns/1ps
`default_nettype none
module pmx_port_ab_mux #(
  parameter int W = pmx_pkg::PORT_W
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic         clk_en,
  // port registers and globals
  input  wire logic [W-1:0] porta_dir,
  input  wire logic [W-1:0] porta_out,
  input  wire logic [W-1:0] portb_dir,
  input  wire logic [W-1:0] portb_out,
  input  wire logic         global_pullup_disable,
  input  wire logic         sleep_clamp,
  // display controller
  input  wire logic         display_drive_on,
  input  wire logic [3:1]   display_mux_select,
  // timers
  input  wire logic [3:0]   timer_out_enable,
  input  wire logic         timer2_compare_a_out,
  input  wire logic         timer1_compare_b_out,
  input  wire logic         timer1_compare_a_out,
  input  wire logic         timer0_compare_a_out,
  // spi unit
  input  wire logic         spi_enable,
  input  wire logic         spi_master,
  input  wire logic         spi_slave_data_out,
  input  wire logic         spi_master_data_out,
  input  wire logic         spi_clock_out,
  output logic              spi_master_data_in,
  output logic              spi_slave_data_in,
  output logic              spi_clock_in,
  output logic              spi_slave_select_n,
  // pin change logic
  input  wire logic [W-1:0] pin_change_enable,
  output logic [W-1:0]      pin_change_src,
  // pads of port a
  input  wire logic [W-1:0] porta_pad_in,
  output logic [W-1:0]      porta_pad_out,
  output logic [W-1:0]      porta_pad_oe,
  output logic [W-1:0]      porta_pullup,
  output logic [W-1:0]      porta_input_en,
  output logic [3:0]        front_plane_line,
  output logic [3:0]        back_plane_line,
  // pads of port b
  input  wire logic [W-1:0] portb_pad_in,
  output logic [W-1:0]      portb_pad_out,
  output logic [W-1:0]      portb_pad_oe,
  output logic [W-1:0]      portb_pullup,
  output logic [W-1:0]      portb_input_en
);

  // generic per-pin override resolution
  function automatic logic [3:0] pmx_resolve(
    input logic dir, input logic port, input logic pu_dis, input logic slp,
    input logic pu_ovr_en, input logic pu_ovr_val, input logic dd_ovr_en,
    input logic dd_ovr_val, input logic pv_ovr_en, input logic pv_ovr_val,
    input logic ie_ovr_en, input logic ie_ovr_val);
    logic pu;
    logic oe;
    logic val;
    logic ie;
    pu  = pu_ovr_en ? pu_ovr_val : ({dir, port, pu_dis} == pmx_pkg::PU_NORMAL);
    oe  = dd_ovr_en ? dd_ovr_val : dir;
    val = pv_ovr_en ? pv_ovr_val : port;
    ie  = ie_ovr_en ? ie_ovr_val : !slp;
    return {pu, oe, val, ie};
  endfunction

  // two-stage synchronisers for pad inputs
  logic [W-1:0] pa_s1_ff, pa_s2_ff, pb_s1_ff, pb_s2_ff;
  logic [W-1:0] nxt_pa_s1, nxt_pa_s2, nxt_pb_s1, nxt_pb_s2;
  logic [W-1:0] pa_out_ff, pa_oe_ff, pa_pu_ff, pa_ie_ff;
  logic [W-1:0] pb_out_ff, pb_oe_ff, pb_pu_ff, pb_ie_ff;
  logic [W-1:0] nxt_pa_out, nxt_pa_oe, nxt_pa_pu, nxt_pa_ie;
  logic [W-1:0] nxt_pb_out, nxt_pb_oe, nxt_pb_pu, nxt_pb_ie;
  logic [W-1:0] pcs_ff, nxt_pcs;
  logic [3:0]   fp_ff, bp_ff, nxt_fp, nxt_bp;
  logic [3:0]   sp_ff, nxt_sp;

  always_comb begin
    logic [3:0] r;
    logic       own;
    logic       ms;
    logic       sl;
    logic [3:0] tv;
    logic [3:0] msel4;
    r   = 4'h0;
    msel4 = {display_mux_select, 1'b1};
    own = 1'b0;
    ms  = spi_enable & spi_master;
    sl  = spi_enable & !spi_master;
    tv  = {timer2_compare_a_out, timer1_compare_b_out,
           timer1_compare_a_out, timer0_compare_a_out};
    nxt_pa_s1 = porta_pad_in;
    nxt_pa_s2 = pa_s1_ff;
    nxt_pb_s1 = portb_pad_in;
    nxt_pb_s2 = pb_s1_ff;
    nxt_pa_out = '0;
    nxt_pa_oe  = '0;
    nxt_pa_pu  = '0;
    nxt_pa_ie  = '0;
    nxt_pb_out = '0;
    nxt_pb_oe  = '0;
    nxt_pb_pu  = '0;
    nxt_pb_ie  = '0;
    for (int i = 0; i < W; i++) begin
      // port a: display ownership
      if (i >= pmx_pkg::FRONT_LO) begin
        own = display_drive_on;
      end else if (i == 0) begin
        own = display_drive_on;
      end else begin
        own = display_drive_on & msel4[i[1:0]];
      end
      r = pmx_resolve(porta_dir[i], porta_out[i], global_pullup_disable, sleep_clamp,
                      own, 1'b0, own, 1'b0, 1'b0, 1'b0, own, 1'b0);
      {nxt_pa_pu[i], nxt_pa_oe[i], nxt_pa_out[i], nxt_pa_ie[i]} = r;
      // port b: timers, spi, pin change
      if (pmx_pkg::PB_TIMER_MASK[i]) begin
        own = timer_out_enable[i[1:0]];
        r = pmx_resolve(portb_dir[i], portb_out[i], global_pullup_disable, sleep_clamp,
                        1'b0, 1'b0, 1'b0, 1'b0, own, tv[i[1:0]],
                        pin_change_enable[i], 1'b1);
      end else begin
        // forced inputs: master on pb3, slave on pb2/pb1/pb0
        own = (i == pmx_pkg::BIT_MISO) ? ms : sl;
        r = pmx_resolve(portb_dir[i], portb_out[i], global_pullup_disable, sleep_clamp,
                        own, portb_out[i] & !global_pullup_disable,
                        own, 1'b0, 1'b0, 1'b0, pin_change_enable[i], 1'b1);
        // driven pins follow direction bit
        if (i == pmx_pkg::BIT_MISO && sl) r[1] = spi_slave_data_out;
        if (i == pmx_pkg::BIT_MOSI && ms) r[1] = spi_master_data_out;
        if (i == pmx_pkg::BIT_SCK && ms) r[1] = spi_clock_out;
      end
      {nxt_pb_pu[i], nxt_pb_oe[i], nxt_pb_out[i], nxt_pb_ie[i]} = r;
    end
    nxt_pcs = pb_s2_ff;
    nxt_fp  = pa_s2_ff[7:4];
    nxt_bp  = pa_s2_ff[3:0];
    nxt_sp  = {pb_s2_ff[pmx_pkg::BIT_MISO], pb_s2_ff[pmx_pkg::BIT_MOSI],
               pb_s2_ff[pmx_pkg::BIT_SCK], pb_s2_ff[pmx_pkg::BIT_SS]};
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pa_s1_ff  <= pmx_pkg::PB_RESET;
      pa_s2_ff  <= pmx_pkg::PB_RESET;
      pb_s1_ff  <= pmx_pkg::PB_RESET;
      pb_s2_ff  <= pmx_pkg::PB_RESET;
      pa_out_ff <= pmx_pkg::PB_RESET;
      pa_oe_ff  <= pmx_pkg::PB_RESET;
      pa_pu_ff  <= pmx_pkg::PB_RESET;
      pa_ie_ff  <= pmx_pkg::PB_RESET;
      pb_out_ff <= pmx_pkg::PB_RESET;
      pb_oe_ff  <= pmx_pkg::PB_RESET;
      pb_pu_ff  <= pmx_pkg::PB_RESET;
      pb_ie_ff  <= pmx_pkg::PB_RESET;
      pcs_ff    <= pmx_pkg::PB_RESET;
      fp_ff     <= 4'h0;
      bp_ff     <= 4'h0;
      sp_ff     <= 4'hF;
    end else if (clk_en) begin
      pa_s1_ff  <= nxt_pa_s1;
      pa_s2_ff  <= nxt_pa_s2;
      pb_s1_ff  <= nxt_pb_s1;
      pb_s2_ff  <= nxt_pb_s2;
      pa_out_ff <= nxt_pa_out;
      pa_oe_ff  <= nxt_pa_oe;
      pa_pu_ff  <= nxt_pa_pu;
      pa_ie_ff  <= nxt_pa_ie;
      pb_out_ff <= nxt_pb_out;
      pb_oe_ff  <= nxt_pb_oe;
      pb_pu_ff  <= nxt_pb_pu;
      pb_ie_ff  <= nxt_pb_ie;
      pcs_ff    <= nxt_pcs;
      fp_ff     <= nxt_fp;
      bp_ff     <= nxt_bp;
      sp_ff     <= nxt_sp;
    end
  end

  assign porta_pad_out      = pa_out_ff;
  assign porta_pad_oe       = pa_oe_ff;
  assign porta_pullup       = pa_pu_ff;
  assign porta_input_en     = pa_ie_ff;
  assign portb_pad_out      = pb_out_ff;
  assign portb_pad_oe       = pb_oe_ff;
  assign portb_pullup       = pb_pu_ff;
  assign portb_input_en     = pb_ie_ff;
  assign pin_change_src     = pcs_ff;
  assign front_plane_line   = fp_ff;
  assign back_plane_line    = bp_ff;
  assign spi_master_data_in = sp_ff[3];
  assign spi_slave_data_in  = sp_ff[2];
  assign spi_clock_in       = sp_ff[1];
  assign spi_slave_select_n = sp_ff[0];

  a_front_pins_off: assert property (@(posedge clock) disable iff (!rst_n)
    (clk_en && display_drive_on) |=> (porta_pad_oe[7:4] == 4'h0 && porta_pullup[7:4] == 4'h0
      && porta_input_en[7:4] == 4'h0))
    else $error("segment pins not released while display on");
  a_plane0_off: assert property (@(posedge clock) disable iff (!rst_n)
    (clk_en && display_drive_on) |=> !porta_pad_oe[0] && !porta_input_en[0])
    else $error("common 0 pin not released while display on");
  a_plane_mux_gate: assert property (@(posedge clock) disable iff (!rst_n)
    (clk_en && !display_drive_on) |=> porta_pad_oe == $past(porta_dir))
    else $error("port a driver overridden without display");
  a_miso_input: assert property (@(posedge clock) disable iff (!rst_n)
    (clk_en && spi_enable && spi_master) |=> !portb_pad_oe[3])
    else $error("miso driven in master mode");
  a_mosi_input: assert property (@(posedge clock) disable iff (!rst_n)
    (clk_en && spi_enable && !spi_master) |=> !portb_pad_oe[2] && !portb_pad_oe[1])
    else $error("mosi or sck driven in slave mode");
  a_miso_slave_dir: assert property (@(posedge clock) disable iff (!rst_n)
    (clk_en && spi_enable && !spi_master) |=> portb_pad_oe[3] == $past(portb_dir[3]))
    else $error("miso direction not from direction bit");
  a_timer_out: assert property (@(posedge clock) disable iff (!rst_n)
    (clk_en && timer_out_enable[3]) |=> portb_pad_out[7] == $past(timer2_compare_a_out))
    else $error("timer2 output not on pb7");
  a_pin_change: assert property (@(posedge clock) disable iff (!rst_n)
    (clk_en && $past(clk_en) && $past(clk_en, 2) && $past(clk_en, 3)) |->
      pin_change_src == $past(portb_pad_in, 3))
    else $error("pin change source mismatch");
  a_forced_pullup: assert property (@(posedge clock) disable iff (!rst_n)
    (clk_en && spi_enable && spi_master) |=>
      portb_pullup[3] == ($past(portb_out[3]) && !$past(global_pullup_disable)))
    else $error("forced input pull-up wrong");

endmodule
`default_nettype wire

// ### tb/pmx_periph_model.sv
// peripheral side model feeding override requests to the mux
`timescale 1ns/1ps
`default_nettype none
module pmx_periph_model (
  // control word from the bench
  input  wire logic [31:0] ctl,
  // display, timer, spi and pin change requests
  output logic      [3:1]  display_mux_select,
  output logic      [3:0]  timer_out_enable,
  output logic      [3:0]  timer_val,
  output logic             spi_enable,
  output logic             spi_master,
  output logic      [2:0]  spi_outs,
  output logic      [7:0]  pin_change_enable
);
  // duty field selects how many common planes are in use
  assign display_mux_select = {ctl[1:0] == 2'h3, ctl[1:0] >= 2'h2, ctl[1:0] != 2'h0};
  assign timer_out_enable   = ctl[5:2];
  assign timer_val          = ctl[9:6];
  assign {spi_master, spi_enable} = ctl[11:10];
  assign spi_outs           = ctl[14:12];
  assign pin_change_enable  = ctl[23:16];
endmodule
`default_nettype wire

// ### tb/tb.sv
// bench for the port a/b alternate function mux
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clock = 1'b0, rst_n = 1'b0, clk_en = 1'b1, gpd = 1'b0, slp = 1'b0, ddon = 1'b0;
  logic [7:0]  adir = '0, aout = '0, bdir = '0, bout = '0, apad = '0, bpad = '0;
  logic [31:0] ctl = '0, seed = 32'h63ABCA09, r;
  logic [3:1]  msel;
  logic [3:0]  toe, tv, fpl, bpl;
  logic [2:0]  so;
  logic        spe, mst, mdi, sdi, sci, ssn;
  logic [7:0]  pce, pcs, aoutp, aoe, apu, aie, boutp, boe, bpu, bie;
  logic [7:0]  e_aoe, e_apu, e_aie, e_aout, e_bout, e_boe, e_bpu, e_bie, e_pad, e_pcs;
  logic [7:0]  e_spi, m_spi;
  int          failures = 0, cmp_count = 0, cyc = 0;

  pmx_periph_model i_pmx_periph_model (.ctl(ctl), .display_mux_select(msel),
    .timer_out_enable(toe), .timer_val(tv), .spi_enable(spe), .spi_master(mst),
    .spi_outs(so), .pin_change_enable(pce));
  pmx_port_ab_mux i_pmx_port_ab_mux (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
    .porta_dir(adir), .porta_out(aout), .portb_dir(bdir), .portb_out(bout),
    .global_pullup_disable(gpd), .sleep_clamp(slp), .display_drive_on(ddon),
    .display_mux_select(msel), .timer_out_enable(toe), .timer2_compare_a_out(tv[3]),
    .timer1_compare_b_out(tv[2]), .timer1_compare_a_out(tv[1]), .timer0_compare_a_out(tv[0]),
    .spi_enable(spe), .spi_master(mst), .spi_slave_data_out(so[2]),
    .spi_master_data_out(so[1]), .spi_clock_out(so[0]), .spi_master_data_in(mdi),
    .spi_slave_data_in(sdi), .spi_clock_in(sci), .spi_slave_select_n(ssn),
    .pin_change_enable(pce), .pin_change_src(pcs), .porta_pad_in(apad),
    .porta_pad_out(aoutp), .porta_pad_oe(aoe), .porta_pullup(apu), .porta_input_en(aie),
    .front_plane_line(fpl), .back_plane_line(bpl), .portb_pad_in(bpad),
    .portb_pad_out(boutp), .portb_pad_oe(boe), .portb_pullup(bpu), .portb_input_en(bie));

  always #5 clock = ~clock;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic void calc();
    logic [7:0] ov, fm;
    ov = {{4{ddon}}, {msel, 1'b1} & {4{ddon}}};
    e_aoe = ~ov & adir;
    e_apu = ~ov & ~adir & aout & {8{~gpd}};
    e_aie = ~ov & {8{~slp}};
    e_aout = aout;
    fm = spe ? (mst ? 8'h08 : 8'h07) : 8'h00;
    e_boe = ~fm & bdir;
    e_bpu = (fm & bout & {8{~gpd}}) | (~fm & ~bdir & bout & {8{~gpd}});
    e_bie = pce | {8{~slp}};
    e_bout = bout;
    for (int k = 0; k < 4; k++) if (toe[k]) e_bout[4+k] = tv[k];
    if (spe && !mst) e_bout[3] = so[2];
    if (spe && mst) e_bout[2:1] = so[1:0];
    e_pad = apad;
    e_pcs = bpad;
    e_spi = {4'h0, bpad[3:0]};
    m_spi = spe ? (mst ? 8'h08 : 8'h07) : 8'h00;
  endfunction

  task automatic cmp(input string nm, input logic [7:0] s, input logic [7:0] e, input logic [7:0] m);
    cmp_count++;
    if (((s ^ e) & m) !== 8'h00) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e & m, s & m);
    end
  endtask

  task automatic chk_ctl();
    cmp("porta_pad_oe", aoe, e_aoe, 8'hFF);
    cmp("porta_pullup", apu, e_apu, 8'hFF);
    cmp("porta_input_en", aie, e_aie, 8'hFF);
    cmp("porta_pad_out", aoutp, e_aout, e_aoe);
    cmp("portb_pad_oe", boe, e_boe, 8'hFF);
    cmp("portb_pullup", bpu, e_bpu, 8'hFF);
    cmp("portb_input_en", bie, e_bie, 8'hFF);
    cmp("portb_pad_out", boutp, e_bout, e_boe);
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      stop_test();
    end
  end

  initial begin
    repeat (5) @(negedge clock);
    cmp("reset_oe", aoe | boe, 8'h00, 8'hFF);
    cmp("reset_spi_in", {4'h0, mdi, sdi, sci, ssn}, 8'h0F, 8'hFF);
    rst_n = 1'b1;
    for (int i = 0; i < 300; i++) begin
      @(negedge clock);
      {adir, aout, bdir, bout} = rnd();
      r = rnd();
      {apad, bpad, gpd, slp, ddon} = r[18:0];
      ctl = rnd();
      if (i < 4) begin
        ddon = 1'b1;
        ctl[1:0] = i[1:0];
      end
      if (i == 4 || i == 5) ctl[11:10] = {i[0], 1'b1};
      if (i == 6) begin
        slp = 1'b1;
        ctl[23:16] = 8'hA5;
      end
      clk_en = (i % 10 != 9);
      #1;
      if (clk_en) calc();
      @(posedge clock);
      #1 chk_ctl();
      repeat (3) @(posedge clock);
      #1 chk_ctl();
      cmp("planes", {fpl, bpl}, e_pad, 8'hFF);
      cmp("pin_change_src", pcs, e_pcs, 8'hFF);
      cmp("spi_in_pads", {4'h0, mdi, sdi, sci, ssn}, e_pcs, 8'h0F);
      cmp("spi_in", {4'h0, mdi, sdi, sci, ssn}, e_spi, m_spi);
      $display("test %0d done", i);
    end
    stop_test();
  end
endmodule
`default_nettype wire
